/* File: hdl/ibs_map.vh */
// Constants for the bus status flag block: addresses, bit positions,
// reset values and bus frame counts.
// Assumes inclusion by bare name from every design file of the block.
//
// Functional notes
// - Reset clears whole status register to zero.
// - Each status read inserts one CPU wait cycle.
// - Eight read-only flags in documented bit order.
// - Master active set on generated start.
// - Master active cleared: stop, loss, release, disable.
// - Arbitration loss sets flag, clears master active.
// - Arbitration flag cleared by read, disable, reset.
// - Bit operation elsewhere clears arbitration flag.
// - Extension code set on eighth clock, nibble 0/F.
// - Extension cleared: start, stop, release, disable.
// - Release is control bit 6, enable bit 7.
// - Address match set on eighth clock, same clears.
// - Data line driven only while transmit flag set.
`ifndef IBS_MAP_VH
`define IBS_MAP_VH

// CPU addresses of the status register and of the snooped control register.
`define IBS_STATUS_ADDR   16'hFFAA
`define IBS_CONTROL_ADDR  16'hFFA6

// Reset value of the status register.
`define IBS_STATUS_RESET  8'h00

// Status bit positions.
`define IBS_BIT_MASTER    7
`define IBS_BIT_ARBLOST   6
`define IBS_BIT_EXTCODE   5
`define IBS_BIT_ADDRMATCH 4
`define IBS_BIT_TRANSMIT  3
`define IBS_BIT_ACKSEEN   2
`define IBS_BIT_STARTSEEN 1
`define IBS_BIT_STOPSEEN  0

// Control register bit positions.
`define IBS_CTRL_ENABLE   7
`define IBS_CTRL_RELEASE  6

// Upper address nibbles that mark an extension code.
`define IBS_EXT_LOW       4'h0
`define IBS_EXT_HIGH      4'hF

// Clock counts within one bus byte.
`define IBS_ADDR_EDGE     4'h8
`define IBS_ACK_EDGE      4'h9

`endif

/* File: hdl/ibs_bus_watch.v */
// Bus watcher: synchronises the clock and data lines and reports start,
// stop, the eighth clock of the address byte and the ninth clock.
// Assumes the pins are asynchronous to clock and slower than it.
`include "ibs_map.vh"

module ibs_bus_watch (
   input  wire       clock,
   input  wire       rstN,
   input  wire       sclPin,
   input  wire       sdaPin,
   output reg        startDet,
   output reg        stopDet,
   output reg        addrEdge,
   output reg        ackEdge,
   output reg        ackLow,
   output reg  [7:0] addrByte
);

   reg [1:0] sclSync_q;
   reg [1:0] sdaSync_q;
   reg       sclOld_q;
   reg       sdaOld_q;
   reg [3:0] bitCnt_q;
   reg       firstByte_q;
   reg [7:0] shift_q;
   wire      sclRise;
   wire      sdaFall;
   wire      sdaRise;

   // Only the second stage of each synchroniser feeds the edge logic.
   assign sclRise = sclSync_q[1] & ~sclOld_q;
   assign sdaFall = ~sdaSync_q[1] & sdaOld_q;
   assign sdaRise = sdaSync_q[1] & ~sdaOld_q;

   // Two-stage synchronisers and one cycle of history for edges.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         sclSync_q <= 2'h3;
         sdaSync_q <= 2'h3;
         sclOld_q  <= 1'b1;
         sdaOld_q  <= 1'b1;
      end else begin
         sclSync_q <= {sclSync_q[0], sclPin};
         sdaSync_q <= {sdaSync_q[0], sdaPin};
         sclOld_q  <= sclSync_q[1];
         sdaOld_q  <= sdaSync_q[1];
      end
   end

   // Frame tracking: a data edge while the clock is high is start or stop.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         bitCnt_q    <= 4'h0;
         firstByte_q <= 1'b0;
         shift_q     <= 8'h00;
         startDet    <= 1'b0;
         stopDet     <= 1'b0;
         addrEdge    <= 1'b0;
         ackEdge     <= 1'b0;
         ackLow      <= 1'b0;
         addrByte    <= 8'h00;
      end else begin
         startDet <= sclSync_q[1] & sclOld_q & sdaFall;
         stopDet  <= sclSync_q[1] & sclOld_q & sdaRise;
         addrEdge <= 1'b0;
         ackEdge  <= 1'b0;
         if (sclSync_q[1] & sclOld_q & sdaFall) begin
            bitCnt_q    <= 4'h0;
            firstByte_q <= 1'b1;
         end else if (sclSync_q[1] & sclOld_q & sdaRise) begin
            bitCnt_q    <= 4'h0;
            firstByte_q <= 1'b0;
         end else if (sclRise) begin
            if (bitCnt_q == `IBS_ADDR_EDGE) begin
               bitCnt_q    <= 4'h0;
               firstByte_q <= 1'b0;
               ackEdge     <= 1'b1;
               ackLow      <= ~sdaSync_q[1];
            end else begin
               bitCnt_q <= bitCnt_q + 4'h1;
               shift_q  <= {shift_q[6:0], sdaSync_q[1]};
               if ((bitCnt_q == `IBS_ADDR_EDGE - 4'h1) && firstByte_q) begin
                  addrEdge <= 1'b1;
                  addrByte <= {shift_q[6:0], sdaSync_q[1]};
               end
            end
         end
      end
   end

endmodule

/* File: hdl/ibs_status.v */
// Bus status register of the serial bus interface: eight read-only flags
// with their set and clear conditions, a waited CPU read port and the
// data line output gate.
// Assumes a CPU port on the same clock with one-cycle read and write
// strobes, and a master engine on the same clock that pulses its events.
`include "ibs_map.vh"

module ibs_status (
   input  wire        clock,
   input  wire        resetn,
   input  wire [15:0] cpuAddr,
   input  wire        cpuRd,
   input  wire        cpuWr,
   input  wire        cpuBitOp,
   input  wire [7:0]  cpuWrData,
   output reg  [7:0]  cpuRdData,
   output reg         cpuWait,
   output reg         cpuRdValid,
   input  wire        startGenerated,
   input  wire        arbitrationLost,
   input  wire [7:0]  ownSlaveAddress,
   input  wire        shiftOutLatch,
   input  wire        sclPin,
   input  wire        sdaPin,
   output reg         sdaOut,
   output reg         sdaOe,
   output reg  [7:0]  busStatus
);

   reg  [1:0] rstSync_q;
   wire       rstN;
   reg        enable_q;
   reg        rdPend_q;
   reg        master_q;
   reg        arbLost_q;
   reg        extCode_q;
   reg        addrMatch_q;
   reg        transmit_q;
   reg        ackSeen_q;
   reg        startSeen_q;
   reg        stopSeen_q;
   wire       startDet;
   wire       stopDet;
   wire       addrEdge;
   wire       ackEdge;
   wire       ackLow;
   wire [7:0] addrByte;
   wire       ctrlWrite;
   wire       releaseHit;
   wire       disableHit;
   wire       leaveBus;
   wire       readDone;
   wire       otherBitOp;
   wire       extMatch;
   wire       ownMatch;
   wire [7:0] statusVec;

   // Tells whether an access targets the given register address.
   function hits;
      input [15:0] addr;
      input [15:0] target;
      begin
         hits = (addr == target);
      end
   endfunction

   // Reset is asserted at once and released through two flip-flops.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end

   assign rstN = rstSync_q[1];

   // Line watcher for start, stop and the clock edges inside a byte.
   ibs_bus_watch uWatch (
      .clock    (clock),
      .rstN     (rstN),
      .sclPin   (sclPin),
      .sdaPin   (sdaPin),
      .startDet (startDet),
      .stopDet  (stopDet),
      .addrEdge (addrEdge),
      .ackEdge  (ackEdge),
      .ackLow   (ackLow),
      .addrByte (addrByte)
   );

   // Control register writes are snooped for the release and enable bits.
   assign ctrlWrite  = cpuWr & hits(cpuAddr, `IBS_CONTROL_ADDR);
   assign releaseHit = ctrlWrite & cpuWrData[`IBS_CTRL_RELEASE];
   assign disableHit = ctrlWrite & enable_q
                       & ~cpuWrData[`IBS_CTRL_ENABLE];
   assign leaveBus   = releaseHit | disableHit;

   // A read completes in its own wait cycle.
   assign readDone   = rdPend_q;
   // A bit operation aimed at any other register loses the loss flag.
   assign otherBitOp = cpuBitOp & (cpuRd | cpuWr)
                       & ~hits(cpuAddr, `IBS_STATUS_ADDR);

   // Address byte decode on the eighth clock.
   assign extMatch = (addrByte[7:4] == `IBS_EXT_LOW)
                     | (addrByte[7:4] == `IBS_EXT_HIGH);
   assign ownMatch = (addrByte[7:1] == ownSlaveAddress[7:1]);

   // Flags assembled in their register order.
   assign statusVec = {master_q, arbLost_q, extCode_q, addrMatch_q,
                       transmit_q, ackSeen_q, startSeen_q,
                       stopSeen_q};

   // Shadow of the enable bit so that its falling edge can be seen.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         enable_q <= 1'b0;
      end else if (ctrlWrite) begin
         enable_q <= cpuWrData[`IBS_CTRL_ENABLE];
      end
   end

   // Master active: a generated start sets it, any exit clears it.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         master_q <= 1'b0;
      end else if (stopDet | arbitrationLost | leaveBus) begin
         master_q <= 1'b0;
      end else if (startGenerated) begin
         master_q <= 1'b1;
      end
   end

   // Arbitration lost: a fresh loss wins over a clear in the same cycle.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         arbLost_q <= 1'b0;
      end else if (arbitrationLost) begin
         arbLost_q <= 1'b1;
      end else if (readDone | disableHit | otherBitOp) begin
         arbLost_q <= 1'b0;
      end
   end

   // Extension code and address match: set on the eighth clock.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         extCode_q   <= 1'b0;
         addrMatch_q <= 1'b0;
      end else begin
         if (addrEdge & extMatch) begin
            extCode_q <= 1'b1;
         end else if (startDet | stopDet | leaveBus) begin
            extCode_q <= 1'b0;
         end
         if (addrEdge & ownMatch) begin
            addrMatch_q <= 1'b1;
         end else if (startDet | stopDet | leaveBus) begin
            addrMatch_q <= 1'b0;
         end
      end
   end

   // Transmit direction follows the read/write bit of the address byte.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         transmit_q <= 1'b0;
      end else if (addrEdge & (master_q | ownMatch)) begin
         transmit_q <= master_q ? ~addrByte[0] : addrByte[0];
      end else if (startDet | stopDet | leaveBus) begin
         transmit_q <= 1'b0;
      end
   end

   // Acknowledge, start and stop seen flags.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         ackSeen_q   <= 1'b0;
         startSeen_q <= 1'b0;
         stopSeen_q  <= 1'b0;
      end else begin
         if (ackEdge) begin
            ackSeen_q <= ackLow;
         end else if (startDet | stopDet | disableHit) begin
            ackSeen_q <= 1'b0;
         end
         if (startDet) begin
            startSeen_q <= 1'b1;
         end else if (stopDet | disableHit) begin
            startSeen_q <= 1'b0;
         end
         if (stopDet) begin
            stopSeen_q <= 1'b1;
         end else if (startDet | disableHit) begin
            stopSeen_q <= 1'b0;
         end
      end
   end

   // CPU read port: one wait cycle, then the data with a valid pulse.
   // Writes to the status address have no effect on any flag.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rdPend_q   <= 1'b0;
         cpuWait    <= 1'b0;
         cpuRdValid <= 1'b0;
         cpuRdData  <= 8'h00;
      end else begin
         rdPend_q   <= cpuRd & hits(cpuAddr, `IBS_STATUS_ADDR) & ~rdPend_q;
         cpuWait    <= cpuRd & hits(cpuAddr, `IBS_STATUS_ADDR)
                       & ~rdPend_q;
         cpuRdValid <= rdPend_q;
         if (rdPend_q) begin
            cpuRdData <= statusVec;
         end
      end
   end

   // Status mirror and data line gate, both registered.
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         busStatus <= `IBS_STATUS_RESET;
         sdaOut    <= 1'b1;
         sdaOe     <= 1'b0;
      end else begin
         busStatus <= statusVec;
         sdaOut    <= shiftOutLatch;
         sdaOe     <= transmit_q;
      end
   end

endmodule

/* File: bench/ibs_status_sva.sv */
// Checker for the bus status block, bound to the ports of ibs_status.
// Assumes one clock domain and a bench that keeps the bus idle around
// control writes and status writes.
module ibs_status_sva (
   input wire        clock,
   input wire        resetn,
   input wire [15:0] cpuAddr,
   input wire        cpuRd,
   input wire        cpuWr,
   input wire        cpuBitOp,
   input wire [7:0]  cpuWrData,
   input wire        cpuWait,
   input wire        cpuRdValid,
   input wire        startGenerated,
   input wire        arbitrationLost,
   input wire        shiftOutLatch,
   input wire        sdaOut,
   input wire        sdaOe,
   input wire [7:0]  busStatus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic enQ;
   wire  ctlWr = cpuWr && cpuAddr == 16'hFFA6;
   wire  stRd  = cpuRd && cpuAddr == 16'hFFAA;
   // Shadow of the last written enable bit, so a disable can be spotted.
   always @(posedge clock or negedge resetn)
      if (!resetn) enQ <= 1'b0;
      else if (ctlWr) enQ <= cpuWrData[7];
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_read_wait: assert property (stRd && !cpuWait |=>
      cpuWait ##1 (cpuRdValid && !cpuWait)) else $error("read answer late");
   a_valid_cause: assert property (cpuRdValid |-> $past(cpuWait))
      else $error("read data without wait");
   a_no_answer: assert property (cpuRd && !stRd |=> !cpuWait)
      else $error("foreign read answered");
   a_arb_read: assert property (cpuRdValid && !arbitrationLost &&
      !$past(arbitrationLost) |=> !busStatus[6]) else $error("loss kept");
   a_loss_master: assert property (arbitrationLost |-> ##2
      (busStatus[6] && !busStatus[7])) else $error("loss not shown");
   a_start_master: assert property (startGenerated &&
      !arbitrationLost && !ctlWr |-> ##2 busStatus[7])
      else $error("master flag not set");
   a_release_clr: assert property (ctlWr && cpuWrData[6] |->
      ##2 (busStatus & 8'hB8) == 8'h00) else $error("release kept flags");
   a_disable_clr: assert property (ctlWr && !cpuWrData[7] && enQ |->
      ##2 busStatus == 8'h00) else $error("disable kept flags");
   a_write_ignore: assert property (cpuWr && cpuAddr == 16'hFFAA |=>
      $stable(busStatus) [*2]) else $error("status write took effect");
   a_bitop_clr: assert property (cpuBitOp && (cpuRd || cpuWr) &&
      cpuAddr != 16'hFFAA && !arbitrationLost |-> ##[1:2] !busStatus[6])
      else $error("bit operation kept loss");
   a_sda_gate: assert property (sdaOe == busStatus[3])
      else $error("data drive not tied to transmit");
   a_sda_data: assert property (sdaOe |-> sdaOut == $past(shiftOutLatch))
      else $error("data line not the latch");
   a_reset_zero: assert property (disable iff (1'b0) !resetn |->
      busStatus == 8'h00 && !sdaOe) else $error("reset value wrong");
endmodule

/* File: bench/ibs_bus_model.sv */
// Far-side bus party: frames start, address bytes and stop.
// Assumes pull-ups on both lines; a high output means released.
module ibs_bus_model (
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time Half = 200ns;
   // Both lines rest released, so the clock stands still between frames.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Start or repeated start, ending with the clock low.
   task automatic start();
      sda = 1'b1;
      #Half scl = 1'b1;
      #Half sda = 1'b0;
      #Half scl = 1'b0;
      #Half;
   endtask
   // Eight bits, most significant first, then a released ninth bit.
   task automatic sendByte(logic [7:0] b);
      for (int i = 8; i >= 0; i--) begin
         sda = (i == 0) ? 1'b1 : b[i-1];
         #Half scl = 1'b1;
         #Half scl = 1'b0;
      end
      #Half;
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda = 1'b0;
      #Half scl = 1'b1;
      #Half sda = 1'b1;
      #Half;
   endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the bus status block with a bus party model.
// Assumes the checker and the bus model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, resetn, cpuRd, cpuWr, cpuBitOp, shiftOutLatch;
   logic        startGenerated, arbitrationLost;
   logic [15:0] cpuAddr;
   logic [7:0]  cpuWrData, ownSlaveAddress, b;
   wire  [7:0]  cpuRdData, busStatus;
   wire         cpuWait, cpuRdValid, sdaOut, sdaOe, sclLine, sdaModel;
   wire         sdaLine = sdaModel & (sdaOut | ~sdaOe);
   int          fails, totalChecks;
   ibs_status ibs_status_inst (.clock(clock), .resetn(resetn),
      .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuBitOp(cpuBitOp),
      .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .cpuWait(cpuWait),
      .cpuRdValid(cpuRdValid), .startGenerated(startGenerated),
      .arbitrationLost(arbitrationLost), .ownSlaveAddress(ownSlaveAddress),
      .shiftOutLatch(shiftOutLatch), .sclPin(sclLine), .sdaPin(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .busStatus(busStatus));
   ibs_bus_model ibs_bus_model_inst (.scl(sclLine), .sda(sdaModel));
   // Free-running clock at 40 MHz.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic check(string what, logic [7:0] e, logic [7:0] g);
      totalChecks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clock);
   endtask
   // One-cycle CPU access, ending in the cycle after it is taken.
   task automatic access(logic w, logic bo, logic [15:0] a, logic [7:0] d);
      @(negedge clock);
      {cpuAddr, cpuWrData, cpuWr, cpuRd, cpuBitOp} = {a, d, w, !w, bo};
      @(negedge clock);
      {cpuWr, cpuRd, cpuBitOp} = 3'b000;
   endtask
   task automatic readStatus(logic [7:0] e);
      access(1'b0, 1'b0, 16'hFFAA, 8'h00);
      check("cpuWait", 8'h01, {7'h00, cpuWait});
      tick(1);
      check("cpuRdValid", 8'h01, {7'h00, cpuRdValid});
      check("cpuRdData", e, cpuRdData);
      tick(2);
   endtask
   task automatic engine(logic s, logic l);
      @(negedge clock);
      {startGenerated, arbitrationLost} = {s, l};
      @(negedge clock);
      {startGenerated, arbitrationLost} = 2'b00;
      tick(3);
   endtask
   function automatic logic [7:0] expFlags(logic [7:0] a);
      return {2'b00, a[7:4] == 4'h0 || a[7:4] == 4'hF,
              a[7:1] == ownSlaveAddress[7:1], 4'h0};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence: CPU side first, then bus frames.
   initial begin
      {cpuRd, cpuWr, cpuBitOp, startGenerated, arbitrationLost} = 5'h00;
      {cpuAddr, cpuWrData, shiftOutLatch, resetn} = {24'h000000, 2'b10};
      void'($urandom(32'hC40B));
      ownSlaveAddress = 8'($urandom);
      tick(10);
      resetn = 1'b1;
      tick(5);
      readStatus(8'h00);
      access(1'b1, 1'b0, 16'hFFA6, 8'h80);
      engine(1'b1, 1'b0);
      readStatus(8'h80);
      engine(1'b0, 1'b1);
      readStatus(8'h40);
      readStatus(8'h00);
      engine(1'b0, 1'b1);
      access(1'b1, 1'b1, 16'hFF20, 8'h01);
      tick(3);
      check("busStatus", 8'h00, busStatus);
      // A bit read of another register gets no wait and drops the loss.
      engine(1'b0, 1'b1);
      access(1'b0, 1'b1, 16'hFF20, 8'h00);
      check("cpuWait", 8'h00, {7'h00, cpuWait});
      tick(3);
      check("busStatus", 8'h00, busStatus);
      $display("test cpu flags done");
      engine(1'b1, 1'b0);
      access(1'b1, 1'b0, 16'hFFAA, 8'h7F);
      tick(3);
      check("busStatus", 8'h80, busStatus);
      access(1'b1, 1'b0, 16'hFFA6, 8'hC0);
      tick(3);
      check("busStatus", 8'h00, busStatus);
      engine(1'b1, 1'b0);
      engine(1'b0, 1'b1);
      access(1'b1, 1'b0, 16'hFFA6, 8'h00);
      tick(3);
      check("busStatus", 8'h00, busStatus);
      access(1'b1, 1'b0, 16'hFFA6, 8'h80);
      engine(1'b1, 1'b0);
      ibs_bus_model_inst.start();
      ibs_bus_model_inst.stop();
      tick(8);
      check("master", 8'h00, busStatus & 8'h80);
      $display("test clears done");
      for (int i = 0; i < 12; i++) begin
         b = (i == 0) ? 8'h0A : (i == 1) ? 8'hF4 : 8'($urandom);
         if (i == 2) b = {ownSlaveAddress[7:1], 1'b0};
         ibs_bus_model_inst.start();
         ibs_bus_model_inst.sendByte(b);
         tick(8);
         check("addr flags", expFlags(b), busStatus & 8'h30);
         ibs_bus_model_inst.start();
         tick(8);
         check("addr flags", 8'h00, busStatus & 8'h30);
         ibs_bus_model_inst.stop();
      end
      ibs_bus_model_inst.start();
      ibs_bus_model_inst.sendByte(8'h0F);
      ibs_bus_model_inst.stop();
      tick(8);
      check("addr flags", 8'h00, busStatus & 8'h30);
      // A release write drops the address flags in mid-frame.
      ibs_bus_model_inst.start();
      ibs_bus_model_inst.sendByte(8'hF0);
      tick(8);
      check("addr flags", expFlags(8'hF0), busStatus & 8'h30);
      access(1'b1, 1'b0, 16'hFFA6, 8'hC0);
      tick(3);
      check("addr flags", 8'h00, busStatus & 8'h30);
      ibs_bus_model_inst.stop();
      $display("test address bytes done");
      ibs_bus_model_inst.start();
      ibs_bus_model_inst.sendByte({ownSlaveAddress[7:1], 1'b1});
      tick(8);
      check("transmit", 8'h08, busStatus & 8'h08);
      check("sdaOe", 8'h01, {7'h00, sdaOe});
      repeat (6) begin
         @(negedge clock) shiftOutLatch = 1'($urandom);
         @(negedge clock);
         check("sdaOut", {7'h00, shiftOutLatch}, {7'h00, sdaOut});
      end
      shiftOutLatch = 1'b1;
      ibs_bus_model_inst.stop();
      tick(8);
      check("sdaOe", 8'h00, {7'h00, sdaOe});
      $display("test transmit done");
      report_and_stop();
   end
   // Watchdog far beyond the expected run length.
   initial begin
      #500000;
      fails++;
      $display("watchdog expired");
      report_and_stop();
   end
endmodule
bind ibs_status ibs_status_sva ibs_status_sva_inst (.clock(clock),
   .resetn(resetn), .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr),
   .cpuBitOp(cpuBitOp), .cpuWrData(cpuWrData), .cpuWait(cpuWait),
   .cpuRdValid(cpuRdValid), .startGenerated(startGenerated),
   .arbitrationLost(arbitrationLost), .shiftOutLatch(shiftOutLatch),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .busStatus(busStatus));
